// *** src/cpmc_power_mode_control.sv ***
// Purpose: power policy unit sequencing cluster power domains and internal resets
// Assumes: mode requests from a system power controller, one per stable period
// Notes:   reset outputs are active low and in the policy unit clock domain
`timescale 1ns/10ps

module cpmc_power_mode_control #(
  parameter int unsigned NUM_CORES     = 4,
  parameter int unsigned NUM_COMPLEXES = 1,
  parameter int unsigned NUM_SLICES    = 4,
  parameter bit          HAS_VECTOR    = 1'b1
) (
  // clock and resets
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cluster_cold_reset_n_i,
  // mode request
  input  wire logic                     mode_req_i,
  input  wire logic [3:0]               mode_target_i,
  input  wire logic                     slice_group_on_i,
  input  wire logic                     ram_half_off_i,
  input  wire logic [NUM_CORES-1:0]     core_power_on_i,
  output logic                          mode_ack_o,
  output logic [3:0]                    mode_current_o,
  output logic                          busy_o,
  // cluster domain controls
  output logic                          cluster_power_on_o,
  output logic                          cluster_func_reset_n_o,
  output logic                          cluster_debug_reset_n_o,
  output logic                          ras_reset_n_o,
  output logic                          cache_invalidate_o,
  output logic                          snoop_ram_retain_o,
  output logic                          snoop_ram_power_on_o,
  // core and complex domains
  output logic [NUM_CORES-1:0]          core_power_on_o,
  output logic [NUM_CORES-1:0]          core_reset_n_o,
  output logic [NUM_CORES-1:0]          core_bridge_power_on_o,
  output logic [NUM_COMPLEXES-1:0]      complex_power_on_o,
  output logic [NUM_COMPLEXES-1:0]      vector_unit_power_on_o,
  output logic [NUM_COMPLEXES-1:0]      vector_unit_retain_o,
  // cache slice domains
  output logic [NUM_SLICES-1:0]         slice_power_on_o,
  output logic [NUM_SLICES-1:0]         ram_a_power_on_o,
  output logic [NUM_SLICES-1:0]         ram_b_power_on_o,
  output logic [NUM_SLICES-1:0]         ram_retain_o
);

  // ----------------------------------------------------------------------
  // mode register and sequencer
  // ----------------------------------------------------------------------
  cpmc_pkg::cpmc_mode_e  mode;
  cpmc_pkg::cpmc_mode_e  prev_mode;
  cpmc_pkg::cpmc_state_e state;
  logic [7:0]            rst_cnt;
  logic                  cold;
  logic                  slice_grp;
  logic                  half_off;
  logic [NUM_CORES-1:0]  core_req;
  logic                  target_legal;
  logic                  implies_reset;

  // cold reset pin and module reset both act on the policy unit
  // the pin is taken as already synchronous; a raw pad needs a synchroniser first
  assign cold         = rst_i | ~cluster_cold_reset_n_i;
  // refused targets leave mode, options and outputs untouched
  assign target_legal = (mode_target_i <= 4'h8);
  assign mode_ack_o   = (state == cpmc_pkg::CPMC_ST_STABLE) & mode_req_i & target_legal & ~cold;
  assign busy_o       = (state != cpmc_pkg::CPMC_ST_STABLE);

  // leaving a powered-down or reset-holding mode toward a live one needs a reset
  always_comb begin
    implies_reset = 1'b0;
    if (mode_target_i == 4'h0 || mode_target_i == 4'h2 || mode_target_i == 4'h3) begin
      implies_reset = (mode == cpmc_pkg::CPMC_OFF) || (mode == cpmc_pkg::CPMC_MEMORY_RETENTION) ||
                      (mode == cpmc_pkg::CPMC_EMU_OFF) || (mode == cpmc_pkg::CPMC_EMU_MEMORY_RETENTION) ||
                      (mode == cpmc_pkg::CPMC_WARM_RST) || (mode == cpmc_pkg::CPMC_DEBUG_RECOVERY_MODE);
    end
    if (mode_target_i == 4'h7 || mode_target_i == 4'h8 || mode_target_i == 4'h5) begin
      implies_reset = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cold) begin
      mode      <= cpmc_pkg::cpmc_mode_e'(cpmc_pkg::CPMC_RESET_MODE);
      prev_mode <= cpmc_pkg::cpmc_mode_e'(cpmc_pkg::CPMC_RESET_MODE);
      state     <= cpmc_pkg::CPMC_ST_STABLE;
      rst_cnt   <= 8'h00;
    end else begin
      unique case (state)
        cpmc_pkg::CPMC_ST_STABLE: begin
          if (mode_ack_o) begin
            prev_mode <= mode;
            mode      <= cpmc_pkg::cpmc_mode_e'(mode_target_i);
            if (implies_reset) begin
              state   <= cpmc_pkg::CPMC_ST_RESET;
              rst_cnt <= 8'(cpmc_pkg::CPMC_RST_PULSE_CYC);
            end
          end
        end
        cpmc_pkg::CPMC_ST_RESET: begin
          if (rst_cnt == 8'h01) begin
            state <= cpmc_pkg::CPMC_ST_SETTLE;
          end
          rst_cnt <= rst_cnt - 8'h01;
        end
        cpmc_pkg::CPMC_ST_SETTLE: begin
          state <= cpmc_pkg::CPMC_ST_STABLE;
        end
        default: begin
          state <= cpmc_pkg::CPMC_ST_STABLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // per-request options
  // ----------------------------------------------------------------------
  // options latch with the mode change, so later pin changes do not leak in
  always_ff @(posedge sys_clk_i) begin
    if (cold) begin
      slice_grp <= 1'b0;
      half_off  <= 1'b0;
      core_req  <= '0;
    end else if (mode_ack_o) begin
      slice_grp <= slice_group_on_i;
      half_off  <= ram_half_off_i;
      core_req  <= core_power_on_i;
    end
  end

  // ----------------------------------------------------------------------
  // domain decode
  // ----------------------------------------------------------------------
  logic logic_pwr;
  logic slice_pwr;
  logic ram_pwr;
  logic ram_ret;
  logic snp_ret;
  logic cores_pwr;
  logic func_hold;
  logic dbg_hold;
  logic in_reset;
  logic keep_ras;
  logic [NUM_SLICES-1:0] slice_en;

  assign in_reset = (state == cpmc_pkg::CPMC_ST_RESET);
  // error registers must survive entry to and exit from debug recovery alike
  assign keep_ras = (mode == cpmc_pkg::CPMC_DEBUG_RECOVERY_MODE) | (prev_mode == cpmc_pkg::CPMC_DEBUG_RECOVERY_MODE);

  always_comb begin
    logic_pwr = 1'b1;
    slice_pwr = 1'b1;
    ram_pwr   = 1'b1;
    ram_ret   = 1'b0;
    snp_ret   = 1'b0;
    cores_pwr = 1'b1;
    func_hold = 1'b0;
    dbg_hold  = 1'b0;
    unique case (mode)
      cpmc_pkg::CPMC_ON: begin
        func_hold = 1'b0;
      end
      cpmc_pkg::CPMC_OFF: begin
        logic_pwr = 1'b0;
        slice_pwr = 1'b0;
        ram_pwr   = 1'b0;
        cores_pwr = 1'b0;
        func_hold = 1'b1;
        dbg_hold  = 1'b1;
      end
      cpmc_pkg::CPMC_FUNCTIONAL_RETENTION: begin
        ram_ret = 1'b1;
        snp_ret = 1'b1;
      end
      cpmc_pkg::CPMC_SLICE_RET: begin
        slice_pwr = 1'b0;
        ram_ret   = 1'b1;
        snp_ret   = 1'b1;
      end
      cpmc_pkg::CPMC_MEMORY_RETENTION: begin
        logic_pwr = 1'b0;
        slice_pwr = 1'b0;
        cores_pwr = 1'b0;
        ram_ret   = 1'b1;
        func_hold = 1'b1;
        dbg_hold  = 1'b1;
      end
      cpmc_pkg::CPMC_EMU_OFF: begin
        func_hold = 1'b1;
      end
      cpmc_pkg::CPMC_EMU_MEMORY_RETENTION: begin
        func_hold = 1'b1;
        ram_ret   = 1'b1;
      end
      cpmc_pkg::CPMC_WARM_RST: begin
        func_hold = 1'b1;
      end
      cpmc_pkg::CPMC_DEBUG_RECOVERY_MODE: begin
        func_hold = 1'b0;
      end
      default: begin
        func_hold = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registered outputs, all launched on the policy unit clock
  // ----------------------------------------------------------------------
  // registering avoids decode glitches on reset lines that cross domains
  always_ff @(posedge sys_clk_i) begin
    if (cold) begin
      mode_current_o          <= cpmc_pkg::CPMC_RESET_MODE;
      cluster_power_on_o      <= 1'b0;
      cluster_func_reset_n_o  <= 1'b0;
      cluster_debug_reset_n_o <= 1'b0;
      ras_reset_n_o           <= 1'b0;
      cache_invalidate_o      <= 1'b0;
      snoop_ram_retain_o      <= 1'b0;
      snoop_ram_power_on_o    <= 1'b0;
    end else begin
      mode_current_o          <= mode;
      cluster_power_on_o      <= logic_pwr;
      cluster_func_reset_n_o  <= ~(func_hold | in_reset);
      cluster_debug_reset_n_o <= ~(dbg_hold | (in_reset & (mode == cpmc_pkg::CPMC_ON)));
      ras_reset_n_o           <= ~(dbg_hold | (in_reset & ~keep_ras));
      cache_invalidate_o      <= in_reset & (mode == cpmc_pkg::CPMC_ON) &
                                 (prev_mode != cpmc_pkg::CPMC_DEBUG_RECOVERY_MODE) &
                                 (prev_mode != cpmc_pkg::CPMC_MEMORY_RETENTION) &
                                 (prev_mode != cpmc_pkg::CPMC_EMU_MEMORY_RETENTION);
      snoop_ram_retain_o      <= snp_ret;
      snoop_ram_power_on_o    <= logic_pwr;
    end
  end

  // ----------------------------------------------------------------------
  // core and complex domains
  // ----------------------------------------------------------------------
  // vector retention stays off: no retention request reaches this block
  always_ff @(posedge sys_clk_i) begin
    if (cold) begin
      core_power_on_o        <= '0;
      core_reset_n_o         <= '0;
      core_bridge_power_on_o <= '0;
      complex_power_on_o     <= '0;
      vector_unit_power_on_o <= '0;
      vector_unit_retain_o   <= '0;
    end else begin
      core_power_on_o        <= core_req & {NUM_CORES{cores_pwr}};
      core_reset_n_o         <= core_req & {NUM_CORES{cores_pwr & ~func_hold & ~in_reset}};
      // cluster half of each bridge follows both core and cluster power
      core_bridge_power_on_o <= core_req & {NUM_CORES{cores_pwr & logic_pwr}};
      complex_power_on_o     <= {NUM_COMPLEXES{cores_pwr}};
      vector_unit_power_on_o <= {NUM_COMPLEXES{cores_pwr & HAS_VECTOR}};
      vector_unit_retain_o   <= {NUM_COMPLEXES{1'b0}};
    end
  end

  // ----------------------------------------------------------------------
  // cache slices
  // ----------------------------------------------------------------------
  // slice 0 alone or the whole group beyond two slices; no finer steps exist
  always_comb begin
    for (int i = 0; i < NUM_SLICES; i++) begin
      slice_en[i] = (i == 0) || (NUM_SLICES <= 2) || slice_grp;
    end
  end

  // registered so slice power gates never see decode glitches
  always_ff @(posedge sys_clk_i) begin
    if (cold) begin
      slice_power_on_o <= '0;
      ram_a_power_on_o <= '0;
      ram_b_power_on_o <= '0;
      ram_retain_o     <= '0;
    end else begin
      slice_power_on_o <= slice_en & {NUM_SLICES{slice_pwr}};
      ram_a_power_on_o <= slice_en & {NUM_SLICES{ram_pwr}};
      ram_b_power_on_o <= slice_en & {NUM_SLICES{ram_pwr & ~half_off}};
      ram_retain_o     <= slice_en & {NUM_SLICES{ram_ret}};
    end
  end

endmodule

// *** src/cpmc_pkg.sv ***
// Purpose: shared constants and types of the cluster power mode control block
// Assumes: one clock, synchronous active-high reset
// Notes:   mode codes are internal to this block
package cpmc_pkg;

  // ----------------------------------------------------------------------
  // cluster power modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CPMC_ON          = 4'h0,
    CPMC_OFF         = 4'h1,
    CPMC_FUNCTIONAL_RETENTION    = 4'h2,
    CPMC_SLICE_RET   = 4'h3,
    CPMC_MEMORY_RETENTION     = 4'h4,
    CPMC_EMU_OFF     = 4'h5,
    CPMC_EMU_MEMORY_RETENTION = 4'h6,
    CPMC_WARM_RST    = 4'h7,
    CPMC_DEBUG_RECOVERY_MODE   = 4'h8
  } cpmc_mode_e;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPMC_ST_STABLE = 2'h0,
    CPMC_ST_RESET  = 2'h1,
    CPMC_ST_SETTLE = 2'h2
  } cpmc_state_e;

  // ----------------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CPMC_CLK_NS        = 25;
  localparam int unsigned CPMC_RST_PULSE_NS  = 400;
  localparam int unsigned CPMC_RST_PULSE_CYC =
    (CPMC_RST_PULSE_NS + CPMC_CLK_NS - 1) / CPMC_CLK_NS;
  localparam logic [3:0]  CPMC_RESET_MODE    = 4'h1;

endpackage

// *** verification/cpmc_spc_model.sv ***
// Purpose: system power controller model issuing mode requests
// Assumes: always-on domain is up before and down after the block
// Notes:   a released target line shows the inverse, never a stale copy
`timescale 1ns/10ps
module cpmc_spc_model (
  // bench side
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] tgt_i,
  // block side
  input  wire logic       mode_ack_i,
  output logic            mode_req_o,
  output logic [3:0]      mode_target_o
);
  logic [3:0] held;
  // requests only come once the always-on side is powered
  assign mode_target_o = mode_req_o ? held : ~held;
  // request held until ack is sampled or go_i falls, then dropped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_req_o <= 1'b0;
      held       <= 4'h0;
    end else if ((mode_req_o && mode_ack_i) || !go_i) begin
      mode_req_o <= 1'b0;
    end else if (!mode_req_o) begin
      mode_req_o <= 1'b1;
      held       <= tgt_i;
    end
  end
endmodule

// *** verification/cpmc_chk_sva.sv ***
// Purpose: port assertions for the cluster power mode control
// Assumes: one clock, resets sampled on the clock
// Notes:   stay needs a mode held two edges, hiding any output lag
`timescale 1ns/10ps
module cpmc_chk #(
  parameter int unsigned NUM_CORES = 4
) (
  // watched ports
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 cluster_cold_reset_n_i,
  input wire logic                 mode_ack_o,
  input wire logic [3:0]           mode_target_i,
  input wire logic [3:0]           mode_current_o,
  input wire logic                 busy_o,
  input wire logic                 cluster_power_on_o,
  input wire logic                 cluster_func_reset_n_o,
  input wire logic                 cluster_debug_reset_n_o,
  input wire logic                 ras_reset_n_o,
  input wire logic                 cache_invalidate_o,
  input wire logic                 snoop_ram_retain_o,
  input wire logic [NUM_CORES-1:0] core_power_on_o
);
  logic [3:0] prev;
  wire logic  stay = (mode_current_o == prev);
  always_ff @(posedge sys_clk_i) begin
    prev <= mode_current_o;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || !cluster_cold_reset_n_i);
  property p_cold; disable iff (rst_i) !cluster_cold_reset_n_i |=> mode_current_o == 4'h1 && !cluster_power_on_o; endproperty
  a_cold: assert property (p_cold) else $error("cold reset not to off");
  property p_pulse; mode_ack_o && mode_target_i == 4'h0 && mode_current_o == 4'h1
    |=> busy_o [*8] ##1 busy_o [*8] ##1 busy_o ##1 !busy_o; endproperty
  a_pulse: assert property (p_pulse) else $error("power-up reset length");
  property p_on; $fell(busy_o) && mode_current_o == 4'h0
    |-> ##[0:2] (cluster_power_on_o && cluster_func_reset_n_o && cluster_debug_reset_n_o); endproperty
  a_on: assert property (p_on) else $error("on mode not released");
  property p_off; stay && mode_current_o == 4'h1 |-> !cluster_power_on_o && core_power_on_o == '0; endproperty
  a_off: assert property (p_off) else $error("off mode powered");
  property p_fret; stay && mode_current_o == 4'h2 |-> cluster_power_on_o && snoop_ram_retain_o; endproperty
  a_fret: assert property (p_fret) else $error("functional retention");
  property p_mret; stay && mode_current_o == 4'h4 |-> !cluster_power_on_o && core_power_on_o == '0; endproperty
  a_mret: assert property (p_mret) else $error("memory retention powered");
  property p_emu; stay && mode_current_o == 4'h5 |-> cluster_power_on_o && !cluster_func_reset_n_o; endproperty
  a_emu: assert property (p_emu) else $error("emulated power-down");
  property p_dbg; mode_ack_o && mode_target_i == 4'h0 && mode_current_o == 4'h8
    |=> (!cache_invalidate_o && ras_reset_n_o) [*8]; endproperty
  a_dbg: assert property (p_dbg) else $error("debug recovery state lost");
endmodule
bind cpmc_power_mode_control cpmc_chk #(.NUM_CORES(NUM_CORES)) u_cpmc_chk (
  .sys_clk_i, .rst_i, .cluster_cold_reset_n_i, .mode_ack_o, .mode_target_i, .mode_current_o, .busy_o,
  .cluster_power_on_o, .cluster_func_reset_n_o, .cluster_debug_reset_n_o, .ras_reset_n_o,
  .cache_invalidate_o, .snoop_ram_retain_o, .core_power_on_o
);

// *** verification/tb.sv ***
// Purpose: self-checking bench for the cluster power mode control
// Assumes: default build, four cores and four slices
// Notes:   all requests pass through the controller model
`timescale 1ns/10ps
module tb;
  logic       sys_clk_i, rst_i, cluster_cold_reset_n_i, go, slice_group_on_i, ram_half_off_i, mode_req_i, mode_ack_o;
  logic       busy_o, cluster_power_on_o, cluster_func_reset_n_o, cluster_debug_reset_n_o, ras_reset_n_o, iseen;
  logic       cache_invalidate_o, snoop_ram_retain_o, rseen, snoop_ram_power_on_o, complex_power_on_o;
  logic       vector_unit_power_on_o, vector_unit_retain_o;
  logic [3:0] core_reset_n_o, core_bridge_power_on_o, ram_a_power_on_o, ram_retain_o;
  logic [3:0] tgt, core_power_on_i, mode_target_i, mode_current_o, core_power_on_o, slice_power_on_o, ram_b_power_on_o;
  int         mismatches, checks, bcnt;
  cpmc_spc_model u_cpmc_spc_model (.sys_clk_i, .rst_i, .go_i(go), .tgt_i(tgt), .mode_ack_i(mode_ack_o),
    .mode_req_o(mode_req_i), .mode_target_o(mode_target_i));
  cpmc_power_mode_control u_cpmc_power_mode_control (.sys_clk_i, .rst_i, .cluster_cold_reset_n_i, .mode_req_i,
    .mode_target_i, .slice_group_on_i, .ram_half_off_i, .core_power_on_i, .mode_ack_o, .mode_current_o, .busy_o,
    .cluster_power_on_o, .cluster_func_reset_n_o, .cluster_debug_reset_n_o, .ras_reset_n_o, .cache_invalidate_o,
    .snoop_ram_retain_o, .snoop_ram_power_on_o, .core_power_on_o, .core_reset_n_o, .core_bridge_power_on_o,
    .complex_power_on_o, .vector_unit_power_on_o, .vector_unit_retain_o, .slice_power_on_o,
    .ram_a_power_on_o, .ram_b_power_on_o, .ram_retain_o);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // options are latched at ack, so they ride with the request
  task automatic go_mode(input logic [3:0] t, input logic g, input logic h, input logic [3:0] c);
    int n;
    n = 0;
    bcnt = 0;
    iseen = 1'b0;
    rseen = 1'b0;
    @(posedge sys_clk_i);
    {go, tgt, slice_group_on_i, ram_half_off_i, core_power_on_i} <= {1'b1, t, g, h, c};
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (mode_ack_o !== 1'b1 && n < 20);
    @(posedge sys_clk_i);
    go <= 1'b0;
    do begin
      @(negedge sys_clk_i);
      bcnt += (busy_o === 1'b1);
      iseen |= (cache_invalidate_o === 1'b1);
      rseen |= (ras_reset_n_o === 1'b0);
    end while (busy_o === 1'b1 && bcnt < 40);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    if (n >= 20 || bcnt >= 40) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic s_on();
    go_mode(4'h0, 1'b1, 1'b0, 4'hF);
    ck("busy", 8'h11, 8'(bcnt));
    ck("inval", 8'h01, iseen);
    ck("pwr", 8'h01, cluster_power_on_o);
    ck("func", 8'h01, cluster_func_reset_n_o);
    ck("slices", 8'h0F, slice_power_on_o);
    ck("ramb", 8'h0F, ram_b_power_on_o);
    ck("ras pulse", 8'h01, rseen);
    ck("core rst", 8'h0F, core_reset_n_o);
    ck("bridge", 8'h0F, core_bridge_power_on_o);
    ck("rama", 8'h0F, ram_a_power_on_o);
    ck("snoop pwr", 8'h01, snoop_ram_power_on_o);
    ck("complex", 8'h01, complex_power_on_o);
    ck("vector", 8'h01, vector_unit_power_on_o);
  endtask
  task automatic s_fret();
    go_mode(4'h2, 1'b0, 1'b1, 4'h5);
    ck("busy", 8'h00, 8'(bcnt));
    ck("snoop", 8'h01, snoop_ram_retain_o);
    ck("slices", 8'h01, slice_power_on_o);
    ck("ramb", 8'h00, ram_b_power_on_o);
    ck("cores", 8'h05, core_power_on_o);
    ck("retain", 8'h01, ram_retain_o);
    ck("rama", 8'h01, ram_a_power_on_o);
    ck("vec ret", 8'h00, vector_unit_retain_o);
  endtask
  task automatic s_sret();
    go_mode(4'h3, 1'b0, 1'b1, 4'h5);
    ck("slices", 8'h00, slice_power_on_o);
    ck("snoop", 8'h01, snoop_ram_retain_o);
    ck("pwr", 8'h01, cluster_power_on_o);
  endtask
  task automatic s_mret();
    go_mode(4'h4, 1'b0, 1'b0, 4'hF);
    ck("pwr", 8'h00, cluster_power_on_o);
    ck("cores", 8'h00, core_power_on_o);
    ck("retain", 8'h01, ram_retain_o);
    ck("bridge", 8'h00, core_bridge_power_on_o);
    ck("complex", 8'h00, complex_power_on_o);
    ck("vector", 8'h00, vector_unit_power_on_o);
    ck("snoop pwr", 8'h00, snoop_ram_power_on_o);
    @(posedge sys_clk_i);
    {go, tgt} <= {1'b1, 4'h9};
    repeat (4) @(negedge sys_clk_i);
    ck("ack", 8'h00, mode_ack_o);
    ck("mode", 8'h04, mode_current_o);
    @(posedge sys_clk_i);
    go <= 1'b0;
  endtask
  task automatic s_emu();
    go_mode(4'h5, 1'b1, 1'b0, 4'hF);
    ck("busy", 8'h11, 8'(bcnt));
    ck("func", 8'h00, cluster_func_reset_n_o);
    ck("dbg", 8'h01, cluster_debug_reset_n_o);
    ck("core rst", 8'h00, core_reset_n_o);
    go_mode(4'h6, 1'b1, 1'b0, 4'hF);
    ck("pwr", 8'h01, cluster_power_on_o);
    ck("dbg", 8'h01, cluster_debug_reset_n_o);
  endtask
  task automatic s_warm_dbg();
    go_mode(4'h7, 1'b1, 1'b0, 4'hF);
    ck("func", 8'h00, cluster_func_reset_n_o);
    go_mode(4'h8, 1'b1, 1'b0, 4'hF);
    go_mode(4'h0, 1'b1, 1'b0, 4'hF);
    ck("inval", 8'h00, iseen);
    ck("ras", 8'h01, ras_reset_n_o);
    ck("ras pulse", 8'h00, rseen);
  endtask
  task automatic s_cold();
    go_mode(4'h1, 1'b1, 1'b0, 4'hF);
    ck("pwr", 8'h00, cluster_power_on_o);
    go_mode(4'h0, 1'b1, 1'b0, 4'hF);
    @(posedge sys_clk_i);
    cluster_cold_reset_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    cluster_cold_reset_n_i <= 1'b1;
    @(negedge sys_clk_i);
    ck("mode", 8'h01, mode_current_o);
    ck("func", 8'h00, cluster_func_reset_n_o);
    go_mode(4'h0, 1'b1, 1'b0, 4'hF);
    ck("busy", 8'h11, 8'(bcnt));
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {rst_i, cluster_cold_reset_n_i, go, tgt, slice_group_on_i, ram_half_off_i, core_power_on_i} = 13'h180F;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    ck("mode", 8'h01, mode_current_o);
    s_on();
    s_fret();
    s_sret();
    s_mret();
    s_emu();
    s_warm_dbg();
    s_cold();
    end_of_test();
  end
endmodule
